// ===== rtl/cbfm_defs.svh
// Register offsets, field positions and reset values for the balance event block
`ifndef CBFM_DEFS_SVH
`define CBFM_DEFS_SVH
`define CBFM_ADDR_FLAGS 8'h2b
`define CBFM_ADDR_MASKS 8'h2c
`define CBFM_FLAGS_RST 8'h00
`define CBFM_MASKS_RST 8'h00
`define CBFM_BIT_TOP 7
`define CBFM_BIT_BOT 6
`define CBFM_EVT_MSB 5
`define CBFM_MASK_RSVD 8'hc0
`define CBFM_INT_PULSE_NS 10
`define CBFM_CLK_NS 10
`define CBFM_INT_CYC ((`CBFM_INT_PULSE_NS + `CBFM_CLK_NS - 1) / `CBFM_CLK_NS)
`endif

// ===== rtl/cbfm_event_latch.sv
// Sticky event flags with clear-on-read, set winning over clear
`timescale 1ns/100ps
`default_nettype none
module cbfm_event_latch #(
  parameter int WIDTH = 6
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic soft_rst,
  input wire logic [WIDTH-1:0] set_evt,
  input wire logic clr,
  output logic [WIDTH-1:0] flags_ff
);
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      flags_ff <= '0;
    end else if (soft_rst) begin
      flags_ff <= '0;
    end else begin
      flags_ff <= (clr ? '0 : flags_ff) | set_evt;
    end
  end
endmodule
`default_nettype wire

// ===== rtl/cbfm_pkg.sv
// Types shared by the balance event block
package cbfm_pkg;
  typedef struct packed {
    logic top_discharge_enable;
    logic bottom_discharge_enable;
    logic [5:0] events;
  } cbfm_flags_s;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cbfm_req_s;
  typedef enum logic {CBFM_IDLE, CBFM_PULSE} cbfm_int_e;
endpackage

// ===== rtl/cbfm_top.sv
// Balance event flags, masks, discharge enables and interrupt pulse
// Function
// - Flag register bit 7 drives the top-cell discharge switch, reset 0.
// - Flag register bit 6 drives the bottom-cell discharge switch, reset 0.
// - Bit 5 latches on entry into or exit from balancing, stays set, clears on read.
// - Bits 4 and 3 latch on upper/lower constant-voltage entry and clear on read.
// - Bits 2 and 1 latch on upper/lower over-voltage, stay set, clear on read.
// - Bit 0 latches on balancing over-current, stays set, clears on read.
// - Mask bits 7 and 6 always read 0.
// - Mask bit 5 blocks the interrupt for balancing transitions.
// - Mask bits 4 and 3 block the constant-voltage interrupts.
// - Mask bits 2 and 1 block the over-voltage interrupts.
// - Mask bit 0 blocks the over-current interrupt.
// - Mask register sits at 2Ch and resets to zero.
// - Flag register sits at 2Bh and resets to zero.
// - Manual discharge acts only while automatic balancing is off.
`timescale 1ns/100ps
`default_nettype none
`include "cbfm_defs.svh"
module cbfm_top
  import cbfm_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic reg_rst,
  input wire logic watchdog_expired,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata_ff,
  input wire logic auto_balance_enable,
  input wire logic balance_active,
  input wire logic upper_cv,
  input wire logic lower_cv,
  input wire logic upper_ov,
  input wire logic lower_ov,
  input wire logic balance_oc,
  output logic top_discharge_switch_ff,
  output logic bottom_discharge_switch_ff,
  output logic int_n_ff
);
  // ----------------------------------------------------------------
  // Request capture and event detection
  // ----------------------------------------------------------------
  cbfm_req_s req;
  cbfm_flags_s flags;
  logic [7:0] masks_ff;
  logic [5:0] cond_prev_ff;
  logic [5:0] cond_now;
  logic [5:0] set_evt;
  logic [5:0] evt_ff;
  logic rd_flags;
  logic wr_flags;
  logic wr_masks;
  logic top_en_ff;
  logic bot_en_ff;
  cbfm_int_e int_state_ff;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
    return a == target;
  endfunction

  assign req = '{wr: reg_wr, rd: reg_rd, addr: reg_addr, wdata: reg_wdata};
  assign rd_flags = req.rd && hit(req.addr, `CBFM_ADDR_FLAGS);
  assign wr_flags = req.wr && hit(req.addr, `CBFM_ADDR_FLAGS);
  assign wr_masks = req.wr && hit(req.addr, `CBFM_ADDR_MASKS);
  assign cond_now = {balance_active, upper_cv, lower_cv, upper_ov, lower_ov, balance_oc};

  // Balancing flag fires on both edges; the others on rising edge only
  assign set_evt = {cond_now[5] ^ cond_prev_ff[5],
                    cond_now[4:3] & ~cond_prev_ff[4:3],
                    cond_now[2:1] & ~cond_prev_ff[2:1],
                    cond_now[0] & ~cond_prev_ff[0]};

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cond_prev_ff <= 6'h00;
    end else begin
      cond_prev_ff <= cond_now;
    end
  end

  // Watchdog input never touches these registers; only a check watches it
  cbfm_event_latch #(.WIDTH(6)) u_latch (
    .mclk(mclk),
    .rst_n(rst_n),
    .soft_rst(reg_rst),
    .set_evt(set_evt),
    .clr(rd_flags),
    .flags_ff(evt_ff)
  );

  // ----------------------------------------------------------------
  // Writable fields
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      top_en_ff <= 1'b0;
      bot_en_ff <= 1'b0;
    end else if (reg_rst) begin
      top_en_ff <= 1'b0;
      bot_en_ff <= 1'b0;
    end else if (wr_flags) begin
      top_en_ff <= req.wdata[`CBFM_BIT_TOP];
      bot_en_ff <= req.wdata[`CBFM_BIT_BOT];
    end
  end
  assign flags = '{top_discharge_enable: top_en_ff, bottom_discharge_enable: bot_en_ff,
                   events: evt_ff};

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      masks_ff <= `CBFM_MASKS_RST;
    end else if (reg_rst) begin
      masks_ff <= `CBFM_MASKS_RST;
    end else if (wr_masks) begin
      masks_ff <= req.wdata & ~`CBFM_MASK_RSVD;
    end
  end

  // ----------------------------------------------------------------
  // Discharge switches
  // ----------------------------------------------------------------
  // Automatic balancing owns the switches while enabled
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      top_discharge_switch_ff <= 1'b0;
      bottom_discharge_switch_ff <= 1'b0;
    end else begin
      top_discharge_switch_ff <= top_en_ff & ~auto_balance_enable;
      bottom_discharge_switch_ff <= bot_en_ff & ~auto_balance_enable;
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_ff <= `CBFM_FLAGS_RST;
    end else if (req.rd) begin
      if (hit(req.addr, `CBFM_ADDR_FLAGS)) begin
        reg_rdata_ff <= flags;
      end else if (hit(req.addr, `CBFM_ADDR_MASKS)) begin
        reg_rdata_ff <= masks_ff & ~`CBFM_MASK_RSVD;
      end else begin
        reg_rdata_ff <= 8'h00;
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt pulse
  // ----------------------------------------------------------------
  logic raise;
  assign raise = |(set_evt & ~masks_ff[5:0]);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      int_state_ff <= CBFM_IDLE;
      int_n_ff <= 1'b1;
    end else begin
      case (int_state_ff)
        CBFM_IDLE: begin
          if (raise) begin
            int_state_ff <= CBFM_PULSE;
            int_n_ff <= 1'b0;
          end
        end
        CBFM_PULSE: begin
          int_state_ff <= CBFM_IDLE;
          int_n_ff <= 1'b1;
        end
        default: begin
          int_state_ff <= CBFM_IDLE;
          int_n_ff <= 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_int_pulse;
    !int_n_ff ##1 int_n_ff;
  endsequence

  a_int_on_event: assert property (@(posedge mclk) disable iff (!rst_n)
    (raise && int_state_ff == CBFM_IDLE) |=> s_int_pulse) else $error("no interrupt pulse");
  a_int_one_cycle: assert property (@(posedge mclk) disable iff (!rst_n)
    !int_n_ff |=> int_n_ff) else $error("interrupt pulse too long");
  a_mask_blocks: assert property (@(posedge mclk) disable iff (!rst_n)
    (int_n_ff && !raise) |=> int_n_ff) else $error("interrupt without unmasked event");
  a_rsvd_zero: assert property (@(posedge mclk) disable iff (!rst_n)
    masks_ff[7:6] == 2'b00) else $error("reserved mask bits set");
  a_ov_sticky: assert property (@(posedge mclk) disable iff (!rst_n)
    (evt_ff[2] && !rd_flags && !reg_rst) |=> evt_ff[2]) else $error("over-voltage flag lost");
  a_oc_latch: assert property (@(posedge mclk) disable iff (!rst_n)
    (balance_oc && !cond_prev_ff[0] && !reg_rst) |=> evt_ff[0]) else $error("over-current missed");
  a_cv_clear: assert property (@(posedge mclk) disable iff (!rst_n)
    (rd_flags && set_evt[4:3] == 2'b00 && !reg_rst) |=> evt_ff[4:3] == 2'b00)
    else $error("cv flags not cleared");
  a_balance_edge: assert property (@(posedge mclk) disable iff (!rst_n)
    ($changed(balance_active) && !reg_rst) |=> evt_ff[5]) else $error("balance edge missed");
  a_manual_gate: assert property (@(posedge mclk) disable iff (!rst_n)
    auto_balance_enable |=> !top_discharge_switch_ff && !bottom_discharge_switch_ff)
    else $error("manual discharge during auto balancing");
  a_reg_reset: assert property (@(posedge mclk) disable iff (!rst_n)
    reg_rst |=> masks_ff == 8'h00 && evt_ff == 6'h00 && !top_en_ff && !bot_en_ff)
    else $error("register reset incomplete");
  a_wdog_ignored: assert property (@(posedge mclk) disable iff (!rst_n)
    (watchdog_expired && !reg_rst && !wr_masks) |=> $stable(masks_ff))
    else $error("watchdog changed mask register");
endmodule
`default_nettype wire

// ===== verification/cbfm_host.sv
// Host model driving the register port of the balance event block
`timescale 1ns/100ps
`default_nettype none
module cbfm_host (
  input wire logic mclk,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata_ff
);
  initial begin
    {reg_wr, reg_rd, reg_addr, reg_wdata} = 18'h0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
    // Released data must not look like the old byte
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata_ff;
  endtask
endmodule
`default_nettype wire

// ===== verification/tb_top.sv
// Self-checking bench for the balance event block
`timescale 1ns/100ps
`default_nettype none
`include "cbfm_defs.svh"
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_errors++; $display("mismatch %s exp %h got %h", nm, e, g); end end
module tb_top;
  logic mclk = 1'b0;
  logic rst_n, reg_rst, watchdog_expired, auto_balance_enable;
  logic reg_wr, reg_rd, top_discharge_switch_ff, bottom_discharge_switch_ff, int_n_ff;
  logic [7:0] reg_addr, reg_wdata, reg_rdata_ff;
  logic [5:0] evt;
  int n_errors = 0;
  int num_checks = 0;
  always #5 mclk = ~mclk;
  cbfm_host cbfm_host_i (.mclk(mclk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff));
  cbfm_top cbfm_top_i (.mclk(mclk), .rst_n(rst_n), .reg_rst(reg_rst),
    .watchdog_expired(watchdog_expired), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff),
    .auto_balance_enable(auto_balance_enable), .balance_active(evt[5]), .upper_cv(evt[4]),
    .lower_cv(evt[3]), .upper_ov(evt[2]), .lower_ov(evt[1]), .balance_oc(evt[0]),
    .top_discharge_switch_ff(top_discharge_switch_ff),
    .bottom_discharge_switch_ff(bottom_discharge_switch_ff), .int_n_ff(int_n_ff));
  // ----------------------------------------
  // Scenario tasks
  // ----------------------------------------
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    cbfm_host_i.rd(a, d);
    `CHK("rdata", e, d)
  endtask
  task automatic t_reset;
    rdchk(`CBFM_ADDR_FLAGS, 8'h00);
    rdchk(`CBFM_ADDR_MASKS, 8'h00);
    `CHK("top", 1'b0, top_discharge_switch_ff)
    `CHK("bot", 1'b0, bottom_discharge_switch_ff)
    $display("test reset done");
  endtask
  task automatic t_regs;
    cbfm_host_i.wr(`CBFM_ADDR_MASKS, 8'hff);
    rdchk(`CBFM_ADDR_MASKS, 8'h3f);
    cbfm_host_i.wr(`CBFM_ADDR_FLAGS, 8'h3f);
    rdchk(`CBFM_ADDR_FLAGS, 8'h00);
    rdchk(8'h2d, 8'h00);
    $display("test registers done");
  endtask
  task automatic settle;
    repeat (3) @(posedge mclk);
    #1;
  endtask
  task automatic t_switch;
    @(posedge mclk);
    auto_balance_enable <= 1'b1;
    cbfm_host_i.wr(`CBFM_ADDR_FLAGS, 8'hc0);
    settle();
    `CHK("top", 1'b0, top_discharge_switch_ff)
    // Host hands the switches over by clearing the automatic mode after writing the enables
    @(posedge mclk);
    auto_balance_enable <= 1'b0;
    settle();
    `CHK("top", 1'b1, top_discharge_switch_ff)
    `CHK("bot", 1'b1, bottom_discharge_switch_ff)
    rdchk(`CBFM_ADDR_FLAGS, 8'hc0);
    cbfm_host_i.wr(`CBFM_ADDR_FLAGS, 8'h40);
    settle();
    `CHK("top", 1'b0, top_discharge_switch_ff)
    `CHK("bot", 1'b1, bottom_discharge_switch_ff)
    cbfm_host_i.wr(`CBFM_ADDR_FLAGS, 8'h00);
    $display("test switches done");
  endtask
  task automatic t_events(input logic masked);
    logic low;
    cbfm_host_i.wr(`CBFM_ADDR_MASKS, masked ? 8'h3f : 8'h00);
    for (int i = 0; i < 6; i++) begin
      low = 1'b0;
      @(posedge mclk);
      evt[i] <= 1'b1;
      // Condition ends at once, so the flag must be sticky
      for (int k = 0; k < 7; k++) begin
        @(posedge mclk);
        if (k == 0) begin
          evt[i] <= 1'b0;
        end
        #1 if (int_n_ff === 1'b0) low = 1'b1;
      end
      `CHK("int_seen", ~masked, low)
      rdchk(`CBFM_ADDR_FLAGS, 8'h01 << i);
      rdchk(`CBFM_ADDR_FLAGS, 8'h00);
    end
    $display("test events masked=%0d done", masked);
  endtask
  task automatic t_regrst;
    cbfm_host_i.wr(`CBFM_ADDR_MASKS, 8'h15);
    cbfm_host_i.wr(`CBFM_ADDR_FLAGS, 8'h80);
    @(posedge mclk);
    watchdog_expired <= 1'b1;
    settle();
    rdchk(`CBFM_ADDR_MASKS, 8'h15);
    rdchk(`CBFM_ADDR_FLAGS, 8'h80);
    @(posedge mclk);
    reg_rst <= 1'b1;
    @(posedge mclk);
    reg_rst <= 1'b0;
    rdchk(`CBFM_ADDR_FLAGS, 8'h00);
    rdchk(`CBFM_ADDR_MASKS, 8'h00);
    settle();
    `CHK("top", 1'b0, top_discharge_switch_ff)
    $display("test register reset done");
  endtask
  // Event and clear-on-read in one cycle: the new event must survive
  task automatic t_setwin;
    logic [7:0] d;
    fork
      cbfm_host_i.rd(`CBFM_ADDR_FLAGS, d);
      begin
        @(posedge mclk);
        evt[0] <= 1'b1;
        @(posedge mclk);
        evt[0] <= 1'b0;
      end
    join
    `CHK("rd_same_cycle", 8'h00, d)
    rdchk(`CBFM_ADDR_FLAGS, 8'h01);
    rdchk(`CBFM_ADDR_FLAGS, 8'h00);
    $display("test set over clear done");
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    {rst_n, reg_rst, watchdog_expired, auto_balance_enable} = 4'h0;
    evt = 6'h00;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    t_reset();
    t_regs();
    t_switch();
    t_events(1'b0);
    t_events(1'b1);
    t_regrst();
    t_setwin();
    give_verdict();
  end
endmodule
`default_nettype wire
